// File: verilog/stats_fetch.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "stats_fetch_map.svh"
module stats_fetch (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    frame_start,
    output stats_fetch_pkg::mem_req_s    mem_req,
    input  wire logic                    mem_ack,
    input  wire logic                    rd_valid,
    input  wire logic [15:0]             rd_word,
    output logic                         pix_valid,
    output logic [9:0]                   pix_data,
    output logic [31:0]                  stats_base_out,
    output logic                         busy
);
    import stats_fetch_pkg::*;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `ADDR_STATS_BASE) || (a == `ADDR_FETCH_START) || (a == `ADDR_FETCH_PITCH) ||
                 (a == `ADDR_FETCH_SIZE) || (a == `ADDR_FETCH_CTRL) || (a == `ADDR_FETCH_STAT);
    endfunction

    logic        setup;
    logic        wr_en;
    logic [31:0] stats_base_q;
    logic [31:0] start_q;
    logic [15:0] pitch_q;
    logic [31:0] size_q;
    logic        ten_bit_q;
    logic        start_req_q;
    frame_cfg_s  cfg_q;
    fetch_state_e state_q;
    logic [11:0] line_cnt_q;
    logic [31:0] line_addr;
    logic        load;
    logic        step;
    logic [12:0] line_bytes;
    logic        win_valid;
    logic [9:0]  win_pixel;

    // Setup cycle samples, access cycle completes with no wait states
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped(paddr);
        end
    end

    // Programmed registers, written even while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stats_base_q <= `ZERO_WORD;
            start_q      <= `ZERO_WORD;
            pitch_q      <= 16'h0000;
            size_q       <= `ZERO_WORD;
            ten_bit_q    <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `ADDR_STATS_BASE:  stats_base_q <= pwdata;
                `ADDR_FETCH_START: start_q      <= pwdata;
                `ADDR_FETCH_PITCH: pitch_q      <= pwdata[15:0];
                `ADDR_FETCH_SIZE:  size_q       <= pwdata & `SIZE_RD_MASK;
                `ADDR_FETCH_CTRL:  ten_bit_q    <= pwdata[`CTRL_TEN_BIT];
                default: ;
            endcase
        end
    end

    // Software start pulse; set by a write, consumed at an idle frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_req_q <= 1'b0;
        end else if (wr_en && paddr == `ADDR_FETCH_CTRL && pwdata[`CTRL_START_BIT]) begin
            start_req_q <= 1'b1;
        end else if (load) begin
            start_req_q <= 1'b0;
        end
    end

    // Read data returns latest written values, reserved bits and start bit as zero; status reads busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `ZERO_WORD;
        end else if (setup && !pwrite) begin
            case (paddr)
                `ADDR_STATS_BASE:  prdata <= stats_base_q;
                `ADDR_FETCH_START: prdata <= start_q;
                `ADDR_FETCH_PITCH: prdata <= {16'h0000, pitch_q} & `PITCH_RD_MASK;
                `ADDR_FETCH_SIZE:  prdata <= size_q & `SIZE_RD_MASK;
                `ADDR_FETCH_CTRL:  prdata <= {30'h0000_0000, ten_bit_q, 1'b0} & `CTRL_RD_MASK;
                `ADDR_FETCH_STAT:  prdata <= {31'h0000_0000, busy};
                default:           prdata <= `ZERO_WORD;
            endcase
        end
    end

    // ----------------------------------------
    // Frame shadow
    // ----------------------------------------
    assign load = frame_start && (state_q == ST_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
        end else if (frame_start) begin
            cfg_q.stats_base <= stats_base_q & `STATS_BASE_MASK;
            if (state_q == ST_IDLE) begin
                cfg_q.start_addr <= start_q & `FETCH_ADDR_MASK;
                cfg_q.pitch      <= pitch_q & `PITCH_EFF_MASK;
                cfg_q.sel        <= size_q[`SEL_HI:`SEL_LO];
                cfg_q.lines      <= size_q[`LINES_HI:`LINES_LO];
                cfg_q.pixels     <= size_q[`PIX_HI:`PIX_LO];
                cfg_q.ten_bit    <= ten_bit_q;
            end
        end
    end

    // Statistics base stays fixed until the next frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stats_base_out <= `ZERO_WORD;
        end else begin
            stats_base_out <= cfg_q.stats_base;
        end
    end

    // ----------------------------------------
    // Fetch sequencer
    // ----------------------------------------
    // Bytes per line: one per 8-bit pixel, two per 10-bit pixel
    assign line_bytes = cfg_q.ten_bit ? {cfg_q.pixels, 1'b0} : {1'b0, cfg_q.pixels};
    assign step = (state_q == ST_WAIT) && mem_ack;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            line_cnt_q <= `ZERO_COUNT;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (load && start_req_q && size_q[`LINES_HI:`LINES_LO] != `ZERO_COUNT) begin
                        state_q    <= ST_LINE;
                        line_cnt_q <= `ZERO_COUNT;
                    end
                end
                ST_LINE: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (mem_ack) begin
                        line_cnt_q <= line_cnt_q + `ONE_COUNT;
                        if (line_cnt_q + `ONE_COUNT == cfg_q.lines) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_LINE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Memory request per line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req <= '0;
            busy    <= 1'b0;
        end else begin
            busy <= (state_q != ST_IDLE);
            if (state_q == ST_LINE) begin
                mem_req.valid <= 1'b1;
                mem_req.addr  <= line_addr;
                mem_req.bytes <= line_bytes;
            end else if (mem_ack) begin
                mem_req.valid <= 1'b0;
            end
        end
    end

    line_walker u_walk (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (load),
        .start_addr (start_q),
        .pitch      (cfg_q.pitch),
        .step       (step),
        .line_addr  (line_addr)
    );

    bit_window u_win (
        .pclk      (pclk),
        .presetn   (presetn),
        .sel       (cfg_q.sel),
        .in_valid  (rd_valid && busy),
        .in_word   (rd_word),
        .out_valid (win_valid),
        .out_pixel (win_pixel)
    );

    // Pixel output register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_valid <= 1'b0;
            pix_data  <= 10'h000;
        end else begin
            pix_valid <= win_valid;
            pix_data  <= win_pixel;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Write to the statistics base
    sequence wr_base_s;
        wr_en && paddr == `ADDR_STATS_BASE;
    endsequence

    // Setup cycle of a read from one place
    sequence read_of_s(logic [11:0] a);
        setup && !pwrite && paddr == a;
    endsequence

    // Idle frame start with a start pending
    sequence frame_go_s;
        load && start_req_q && size_q[`LINES_HI:`LINES_LO] != `ZERO_COUNT;
    endsequence

    // Line state, then first request
    sequence line_issue_s;
        state_q == ST_LINE ##1 mem_req.valid && mem_req.addr == cfg_q.start_addr;
    endsequence

    // ----------------------------------------
    // Register bus checks
    // ----------------------------------------
    // Writes taken while fetching
    write_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && pwrite && busy && mapped(paddr)) |=> pready && !pslverr)
        else $error("write refused while busy");
    // Base write lands at access edge
    write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_base_s |=> stats_base_q == $past(pwdata))
        else $error("base write lost");
    // Pitch write keeps low half
    pitch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `ADDR_FETCH_PITCH) |=> pitch_q == $past(pwdata[15:0]))
        else $error("pitch write lost");
    // Start address readback
    read_back_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_of_s(`ADDR_FETCH_START) |=> prdata == $past(start_q))
        else $error("start address readback wrong");
    // Base readback is the raw value
    base_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_of_s(`ADDR_STATS_BASE) |=> prdata == $past(stats_base_q))
        else $error("base readback wrong");
    // Pitch readback, upper half zero
    pitch_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_of_s(`ADDR_FETCH_PITCH) |=> prdata == {16'h0000, $past(pitch_q)})
        else $error("pitch readback wrong");
    // Size readback reserved bits
    rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_of_s(`ADDR_FETCH_SIZE) |=> prdata[31] == 1'b0 && prdata[15:12] == 4'h0)
        else $error("reserved bits nonzero");

    // ----------------------------------------
    // Frame shadow checks
    // ----------------------------------------
    // Applied base is aligned
    base_align_a: assert property (@(posedge pclk) disable iff (!presetn)
        stats_base_out[5:0] == 6'h00)
        else $error("stats base not 64-byte aligned");
    // Base write alone moves nothing
    base_defer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_base_s and !frame_start) |=> $stable(cfg_q.stats_base))
        else $error("stats base changed mid frame");
    // Base applied after each boundary
    base_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start |=> ##1 stats_base_out == ($past(stats_base_q, 2) & `STATS_BASE_MASK))
        else $error("stats base not applied");
    // Fetch settings loaded at idle start
    shadow_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> cfg_q.start_addr == ($past(start_q) & `FETCH_ADDR_MASK)
            && cfg_q.pitch == ($past(pitch_q) & `PITCH_EFF_MASK))
        else $error("shadow load wrong");
    // Start address and line count fixed in flight
    shadow_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && !frame_start) |=> $stable(cfg_q.start_addr) && $stable(cfg_q.lines))
        else $error("shadow changed while busy");
    // Pitch and window fixed in flight
    pitch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && !frame_start) |=> $stable(cfg_q.pitch) && $stable(cfg_q.sel))
        else $error("pitch changed while busy");

    // ----------------------------------------
    // Fetch checks
    // ----------------------------------------
    // Walker loads the start address
    first_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (load && start_req_q) |=> line_addr == ($past(start_q) & `FETCH_ADDR_MASK))
        else $error("frame start address wrong");
    // Started frame issues its first line
    frame_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        frame_go_s |=> line_issue_s)
        else $error("frame did not start fetching");
    // Empty frame stays idle
    zero_lines_a: assert property (@(posedge pclk) disable iff (!presetn)
        (load && size_q[`LINES_HI:`LINES_LO] == `ZERO_COUNT) |=> state_q == ST_IDLE)
        else $error("empty frame fetched");
    // Requests are aligned
    start_align_a: assert property (@(posedge pclk) disable iff (!presetn)
        mem_req.valid |-> mem_req.addr[4:0] == 5'h00)
        else $error("fetch address not aligned");
    // Request stands until accepted
    req_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mem_req.valid && !mem_ack) |=> mem_req.valid && $stable(mem_req.addr) && $stable(mem_req.bytes))
        else $error("request dropped early");
    // Next line one shadowed pitch on
    addr_pitch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (step && line_cnt_q + `ONE_COUNT != cfg_q.lines)
            |=> ##1 mem_req.addr == $past(mem_req.addr, 2) + {16'h0000, cfg_q.pitch})
        else $error("line pitch wrong");
    // Last line ends the frame
    line_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_WAIT && mem_ack && line_cnt_q + `ONE_COUNT == cfg_q.lines) |=> state_q == ST_IDLE)
        else $error("line count end wrong");
    // Byte count per line
    line_bytes_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_LINE) |=> mem_req.bytes == (cfg_q.ten_bit ? {cfg_q.pixels, 1'b0} : {1'b0, cfg_q.pixels}))
        else $error("line byte count wrong");
    // Busy while lines go out
    busy_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_LINE) |=> busy)
        else $error("busy missing");
    // Words reach the pixel port
    pix_path_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_valid && busy) |=> ##1 pix_valid)
        else $error("pixel lost");
endmodule

// File: include/stats_fetch_map.svh
`ifndef STATS_FETCH_MAP_SVH
`define STATS_FETCH_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_STATS_BASE   12'h000
`define ADDR_FETCH_START  12'h004
`define ADDR_FETCH_PITCH  12'h008
`define ADDR_FETCH_SIZE   12'h00c
`define ADDR_FETCH_CTRL   12'h010
`define ADDR_FETCH_STAT   12'h014

// ----------------------------------------
// Field layout and masks
// ----------------------------------------
`define STATS_BASE_MASK   32'hffff_ffc0
`define FETCH_ADDR_MASK   32'hffff_ffe0
`define PITCH_RD_MASK     32'h0000_ffff
`define PITCH_EFF_MASK    16'hffe0
`define SIZE_RD_MASK      32'h7fff_0fff
`define CTRL_RD_MASK      32'h0000_0002
`define SEL_HI            30
`define SEL_LO            28
`define LINES_HI          27
`define LINES_LO          16
`define PIX_HI            11
`define PIX_LO            0
`define CTRL_START_BIT    0
`define CTRL_TEN_BIT      1
`define SEL_RESERVED      3'h7
`define ZERO_WORD         32'h0000_0000
`define ZERO_COUNT        12'h000
`define ONE_COUNT         12'h001
`define ZERO_BYTES        13'h0000
`define BYTE_STEP_8       13'h0001
`define BYTE_STEP_10      13'h0002

`endif

// File: include/stats_fetch_pkg.sv
package stats_fetch_pkg;
    // Frame settings captured at frame start
    typedef struct packed {
        logic [31:0] stats_base;
        logic [31:0] start_addr;
        logic [15:0] pitch;
        logic [2:0]  sel;
        logic [11:0] lines;
        logic [11:0] pixels;
        logic        ten_bit;
    } frame_cfg_s;

    // Memory read request
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [12:0] bytes;
    } mem_req_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LINE = 3'b010,
        ST_WAIT = 3'b100
    } fetch_state_e;
endpackage

// File: verilog/bit_window.sv
`timescale 1ns/100ps
`include "stats_fetch_map.svh"
module bit_window (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [2:0]  sel,
    input  wire logic        in_valid,
    input  wire logic [15:0] in_word,
    output logic             out_valid,
    output logic [9:0]       out_pixel
);
    // ----------------------------------------
    // Window extraction
    // ----------------------------------------
    function automatic logic [9:0] pick(input logic [2:0] s, input logic [15:0] w);
        logic [15:0] sh;
        sh = w >> s;
        pick = sh[9:0];
    endfunction

    // Registered window output; reserved select yields zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_pixel <= 10'h000;
        end else begin
            out_valid <= in_valid;
            if (sel == `SEL_RESERVED) begin
                out_pixel <= 10'h000;
            end else begin
                out_pixel <= pick(sel, in_word);
            end
        end
    end

    window_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && sel != `SEL_RESERVED) |=> out_pixel == $past(in_word[sel +: 10]))
        else $error("window pixel mismatch");
endmodule

// File: verilog/line_walker.sv
`timescale 1ns/100ps
`include "stats_fetch_map.svh"
module line_walker (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [31:0] start_addr,
    input  wire logic [15:0] pitch,
    input  wire logic        step,
    output logic [31:0]      line_addr
);
    // ----------------------------------------
    // Line address accumulator
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_addr <= `ZERO_WORD;
        end else if (load) begin
            line_addr <= start_addr & `FETCH_ADDR_MASK;
        end else if (step) begin
            line_addr <= line_addr + {16'h0000, pitch & `PITCH_EFF_MASK};
        end
    end

    line_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (step && !load) |=> line_addr == $past(line_addr) + {16'h0000, $past(pitch) & `PITCH_EFF_MASK})
        else $error("line step wrong");
endmodule

// File: sim/mem_model.sv
`timescale 1ns/100ps
module mem_model (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire stats_fetch_pkg::mem_req_s  mem_req,
    output logic                            mem_ack,
    output logic                            rd_valid,
    output logic [15:0]                     rd_word
);
    import stats_fetch_pkg::*;
    logic [1:0] wait_q;

    // ----------------------------------------
    // Memory controller side
    // ----------------------------------------
    // Accept each line request after a random stall of zero to three cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_q  <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            if (mem_req.valid && !mem_ack) begin
                if (wait_q == 2'h0) begin
                    mem_ack <= 1'b1;
                    wait_q  <= 2'($urandom_range(0, 3));
                end else begin
                    wait_q <= wait_q - 2'h1;
                end
            end
        end
    end

    // Words after acceptance or at random while waiting; idle data toggles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_valid <= 1'b0;
            rd_word  <= 16'h0000;
        end else if (mem_ack || (mem_req.valid && $urandom_range(0, 1) == 1)) begin
            rd_valid <= 1'b1;
            rd_word  <= 16'($urandom);
        end else begin
            rd_valid <= 1'b0;
            rd_word  <= ~rd_word;
        end
    end
endmodule

// File: sim/stats_fetch_tb_top.sv
`timescale 1ns/100ps
`include "stats_fetch_map.svh"
module stats_fetch_tb_top;
    import stats_fetch_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        frame_start, mem_ack, rd_valid, pix_valid, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, stats_base_out, rdat, exp_addr, exp_pitch, base_eff;
    logic [15:0] rd_word;
    logic [9:0]  pix_data;
    logic [12:0] exp_bytes;
    logic [2:0]  exp_sel;
    logic [9:0]  pix_q[$];
    mem_req_s    mem_req;
    int          failures, num_checks, n_req, lines, seed_v;
    logic [31:0] shadow[6];

    stats_fetch stats_fetch_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_start(frame_start), .mem_req(mem_req), .mem_ack(mem_ack),
        .rd_valid(rd_valid), .rd_word(rd_word), .pix_valid(pix_valid), .pix_data(pix_data),
        .stats_base_out(stats_base_out), .busy(busy));
    mem_model mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_ack(mem_ack),
        .rd_valid(rd_valid), .rd_word(rd_word));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer, waiting for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            final_report();
        end
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] rmask(input int i);
        case (i)
            2: return `PITCH_RD_MASK;
            3: return `SIZE_RD_MASK;
            4: return `CTRL_RD_MASK;
            5: return `ZERO_WORD;
            default: return 32'hffff_ffff;
        endcase
    endfunction

    task automatic wreg(input int i, input logic [31:0] d);
        apb(1'b1, 12'(i * 4), d);
        check(32'(err), 32'h0000_0000);
        shadow[i] = d;
    endtask

    task automatic rreg(input int i);
        apb(1'b0, 12'(i * 4), 32'h0000_0000);
        check(rdat, shadow[i] & rmask(i));
    endtask

    task automatic pulse;
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
    endtask

    // ----------------------------------------
    // Reference model of the fetch stream
    // ----------------------------------------
    always @(posedge pclk) begin
        if (presetn) begin
            if (pix_valid) begin
                if (pix_q.size() == 0) check(32'h0000_0001, 32'h0000_0000);
                else check(32'(pix_data), 32'(pix_q.pop_front()));
            end
            if (rd_valid && busy) pix_q.push_back(exp_sel == 3'h7 ? 10'h000 : 10'(rd_word >> exp_sel));
            if (mem_req.valid && mem_ack) begin
                check(mem_req.addr, exp_addr);
                check(32'(mem_req.bytes), 32'(exp_bytes));
                exp_addr = exp_addr + exp_pitch;
                n_req++;
            end
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, frame_start} = 4'h0;
        paddr    = 12'h000;
        pwdata   = 32'h0000_0000;
        presetn  = 1'b0;
        failures = 0;
        num_checks = 0;
        n_req    = 0;
        exp_sel  = 3'h0;
        seed_v   = $urandom(34);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then unmapped place
        for (int i = 0; i < 6; i++) begin
            shadow[i] = 32'h0000_0000;
            rreg(i);
        end
        apb(1'b1, 12'h018, 32'hffff_ffff);
        check(32'(err), 32'h0000_0001);
        apb(1'b0, 12'h018, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        check(rdat, 32'h0000_0000);
        $display("test reset and unmapped done");
        // Random write and readback with reserved bits
        for (int i = 0; i < 10; i++) begin
            wreg(i % 5, $urandom);
            rreg(i % 5);
        end
        $display("test register access done");
        // Frames over every window select and both source widths
        wreg(1, $urandom);
        wreg(2, $urandom);
        for (int f = 0; f < 8; f++) begin
            wreg(3, {1'b0, 3'(f), 12'($urandom_range(2, 4)), 4'h0, 12'($urandom_range(1, 4095))});
            wreg(0, $urandom);
            wreg(4, {30'h0000_0000, 1'(f % 2), 1'b1});
            exp_addr  = shadow[1] & `FETCH_ADDR_MASK;
            exp_pitch = {16'h0000, shadow[2][15:0] & `PITCH_EFF_MASK};
            exp_bytes = (f % 2 == 1) ? {shadow[3][11:0], 1'b0} : {1'b0, shadow[3][11:0]};
            exp_sel   = shadow[3][30:28];
            lines     = int'(shadow[3][27:16]);
            n_req     = 0;
            base_eff  = shadow[0] & `STATS_BASE_MASK;
            pulse();
            check(stats_base_out, base_eff);
            wreg(0, $urandom);
            rreg(0);
            check(stats_base_out, base_eff);
            pulse();
            check(stats_base_out, shadow[0] & `STATS_BASE_MASK);
            wreg(1, $urandom);
            wreg(2, $urandom);
            rreg(1);
            rreg(2);
            for (int n = 0; busy !== 1'b0; n++) begin
                if (n > 500) begin
                    failures++;
                    final_report();
                end
                @(posedge pclk);
            end
            repeat (4) @(posedge pclk);
            check(32'(n_req), 32'(lines));
            check(32'(pix_q.size()), 32'h0000_0000);
            rreg(5);
            $display("test frame %0d done", f);
        end
        // Zero line count fetches nothing
        wreg(3, 32'h0000_0010);
        wreg(4, 32'h0000_0001);
        pulse();
        repeat (3) @(posedge pclk);
        check(32'(mem_req.valid), 32'h0000_0000);
        check(32'(busy), 32'h0000_0000);
        $display("test empty frame done");
        final_report();
    end
endmodule
